// ---- common/ee_map.svh ----
`ifndef EE_MAP_SVH
`define EE_MAP_SVH

// ************************************************************
// clock and timing
// ************************************************************
`define EE_CLK_MHZ     100
`define EE_TFILT_NS    100
`define EE_FILT_CYC    ((`EE_TFILT_NS * `EE_CLK_MHZ) / 1000)
`define EE_TWR_US      5000
`define EE_TPU_US      1000
`define EE_TWR_CYC     (`EE_TWR_US * `EE_CLK_MHZ)
`define EE_TPU_CYC     (`EE_TPU_US * `EE_CLK_MHZ)

// ************************************************************
// array layout and address fields
// ************************************************************
`define EE_MEM_BYTES   8192
`define EE_PAGES       128
`define EE_PAGE_BYTES  64
`define EE_ADDR_BITS   13
`define EE_PAGE_BITS   7
`define EE_BYTE_BITS   6
`define EE_ADRH_LSB    0
`define EE_ADRH_MSB    4

// ************************************************************
// slave address byte and bit counter values
// ************************************************************
`define EE_DEV_TYPE    4'ha
`define EE_SA_TYPE_MSB 7
`define EE_SA_TYPE_LSB 4
`define EE_SA_SEL_MSB  3
`define EE_SA_SEL_LSB  1
`define EE_SA_RW_BIT   0
`define EE_ACK_BIT     4'h8
`define EE_LAST_BIT    4'h7

`endif

// ---- common/ee_pkg.sv ----
package ee_pkg;

    // ************************************************************
    // bus states and carriers
    // ************************************************************
    typedef enum logic [2:0] {
        ST_POR,
        ST_IDLE,
        ST_DEVADR,
        ST_ADRH,
        ST_ADRL,
        ST_WDATA,
        ST_RDATA
    } ee_state_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } ee_bus_s;

    typedef struct packed {
        logic       wp;
        logic [2:0] sel;
    } ee_strap_s;

endpackage

// ---- hdl/ee_filter.sv ----
`timescale 1ns/1ps
// two-flop synchroniser followed by a stability filter
module ee_filter #(
    parameter int              WIDTH    = 1,
    parameter int              FILT_CYC = 10,
    parameter logic [WIDTH-1:0] INIT    = '0
) (
    input  wire logic             clk_i,    // block clock
    input  wire logic             rst_n_i,  // async reset, active low
    input  wire logic [WIDTH-1:0] pin_i,    // raw pin levels
    output logic      [WIDTH-1:0] filt_o    // synced, filtered levels
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] filt_ff;
    logic [WIDTH-1:0] nxt_filt;
    logic [7:0]       cnt_ff;
    logic [7:0]       nxt_cnt;

    // meta_ff feeds sync_ff only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= INIT;
            sync_ff <= INIT;
        end else begin
            meta_ff <= pin_i;
            sync_ff <= meta_ff;
        end
    end

    // a new level is taken only once it held for FILT_CYC cycles
    always_comb begin
        nxt_filt = filt_ff;
        nxt_cnt  = 8'h00;
        if (sync_ff != filt_ff) begin
            if (cnt_ff >= 8'(FILT_CYC - 1)) begin
                nxt_filt = sync_ff;
            end else begin
                nxt_cnt = cnt_ff + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            filt_ff <= INIT;
            cnt_ff  <= 8'h00;
        end else begin
            filt_ff <= nxt_filt;
            cnt_ff  <= nxt_cnt;
        end
    end

    assign filt_o = filt_ff;

endmodule

// ---- hdl/ee_slave.sv ----
`timescale 1ns/1ps
`include "ee_map.svh"
module ee_slave #(
    parameter int WR_CYCLES = `EE_TWR_CYC,  // internal write cycle length
    parameter int PU_CYCLES = `EE_TPU_CYC,  // power-up to ready delay
    parameter int FILT_CYC  = `EE_FILT_CYC  // input glitch filter length
) (
    input  wire logic clk_i,              // block clock, 100 MHz
    input  wire logic rst_n_i,            // async reset, active low
    input  wire logic scl_i,              // serial clock from master
    input  wire logic sda_i,              // serial data line level
    output logic      sda_o,              // data drive value, always low
    output logic      sda_oe_o,           // high while pulling data low
    input  wire logic select_strap_bit0_i, // select strap, bit 0
    input  wire logic select_strap_bit1_i, // select strap, bit 1
    input  wire logic select_strap_bit2_i, // select strap, bit 2
    input  wire logic wp_i,               // write protect, high protects
    output logic      ready_o,            // power-up delay has ended
    output logic      busy_o              // internal write cycle running
);
    import ee_pkg::*;

    // ************************************************************
    // pin conditioning
    // ************************************************************
    ee_bus_s   bus;
    ee_bus_s   bus_q_ff;
    ee_strap_s strap;

    // bus lines idle high; 10 cycles sits well inside a 0.6 us high
    ee_filter #(.WIDTH(2), .FILT_CYC(FILT_CYC), .INIT(2'h3)) u_bus_filt (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   ({scl_i, sda_i}),
        .filt_o  (bus)
    );

    // pads pull open straps low, so only a firm high counts
    ee_filter #(.WIDTH(4), .FILT_CYC(1), .INIT(4'h0)) u_strap_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   ({wp_i, select_strap_bit2_i, select_strap_bit1_i, select_strap_bit0_i}),
        .filt_o  (strap)
    );

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    // data edges while clock stays high are bus conditions
    assign scl_rise   = bus.scl & ~bus_q_ff.scl;
    assign scl_fall   = ~bus.scl & bus_q_ff.scl;
    assign start_cond = bus.scl & bus_q_ff.scl & bus_q_ff.sda & ~bus.sda;
    assign stop_cond  = bus.scl & bus_q_ff.scl & ~bus_q_ff.sda & bus.sda;

    // ************************************************************
    // storage
    // ************************************************************
    logic [7:0] mem_arr [`EE_MEM_BYTES];
    logic [7:0] page_buf [`EE_PAGE_BYTES];

    ee_state_e                  state_ff, nxt_state;
    logic [3:0]                 bit_ff, nxt_bit;
    logic [7:0]                 shift_ff, nxt_shift;
    logic                       oe_ff, nxt_oe;
    logic                       mack_ff, nxt_mack;
    logic [`EE_ADDR_BITS-1:0]   ptr_ff, nxt_ptr;
    logic [`EE_PAGE_BYTES-1:0]  mask_ff, nxt_mask;
    logic [`EE_PAGE_BITS-1:0]   page_ff, nxt_page;
    logic                       busy_ff, nxt_busy;
    logic [31:0]                tmr_ff, nxt_tmr;
    logic [6:0]                 cidx_ff, nxt_cidx;
    logic                       buf_we;
    logic                       mem_we;
    logic [`EE_BYTE_BITS-1:0]   cidx_lo;
    logic                       addr_hit;

    assign cidx_lo = cidx_ff[`EE_BYTE_BITS-1:0];

    // slave byte: fixed type, straps, no answer while writing
    assign addr_hit = (shift_ff[`EE_SA_TYPE_MSB:`EE_SA_TYPE_LSB] == `EE_DEV_TYPE)
                    & (shift_ff[`EE_SA_SEL_MSB:`EE_SA_SEL_LSB] == strap.sel)
                    & ~busy_ff;

    // ************************************************************
    // bit engine, write cycle and power-up timer
    // ************************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_bit   = bit_ff;
        nxt_shift = shift_ff;
        nxt_oe    = oe_ff;
        nxt_mack  = mack_ff;
        nxt_ptr   = ptr_ff;
        nxt_mask  = mask_ff;
        nxt_page  = page_ff;
        nxt_busy  = busy_ff;
        nxt_tmr   = tmr_ff;
        nxt_cidx  = cidx_ff;
        buf_we    = 1'b0;
        mem_we    = 1'b0;
        // write cycle: commit one buffered byte per clock, then wait out the time
        if (busy_ff) begin
            if (cidx_ff < 7'(`EE_PAGE_BYTES)) begin
                mem_we   = mask_ff[cidx_lo];
                nxt_cidx = cidx_ff + 7'h01;
            end
            if (tmr_ff <= 32'h0000_0001) begin
                nxt_busy = 1'b0;
            end else begin
                nxt_tmr = tmr_ff - 32'h0000_0001;
            end
        end
        case (state_ff)
            ST_POR: begin
                // commands are ignored until the ready delay ran out
                if (tmr_ff >= 32'(PU_CYCLES - 1)) begin
                    nxt_state = ST_IDLE;
                    nxt_tmr   = 32'h0000_0000;
                end else begin
                    nxt_tmr = tmr_ff + 32'h0000_0001;
                end
            end
            default: begin
                if (start_cond) begin
                    nxt_state = ST_DEVADR;
                    nxt_bit   = 4'hf; // the clock fall ending the start is no bit
                    nxt_oe    = 1'b0;
                end else if (stop_cond) begin
                    nxt_state = ST_IDLE;
                    nxt_oe    = 1'b0;
                    // protected or empty writes start no cycle at all
                    if (state_ff == ST_WDATA && (|mask_ff) && !strap.wp) begin
                        nxt_busy = 1'b1;
                        nxt_tmr  = 32'(WR_CYCLES);
                        nxt_cidx = 7'h00;
                    end
                end else if (state_ff != ST_IDLE && scl_rise) begin
                    if (bit_ff == `EE_ACK_BIT) begin
                        nxt_mack = ~bus.sda;
                    end else if (state_ff != ST_RDATA) begin
                        nxt_shift = {shift_ff[6:0], bus.sda};
                    end
                end else if (state_ff != ST_IDLE && scl_fall) begin
                    if (bit_ff > `EE_ACK_BIT) begin
                        nxt_bit = 4'h0;
                    end else if (bit_ff < `EE_LAST_BIT) begin
                        nxt_bit = bit_ff + 4'h1;
                        if (state_ff == ST_RDATA) begin
                            nxt_shift = {shift_ff[6:0], 1'b0};
                            nxt_oe    = ~shift_ff[6];
                        end
                    end else if (bit_ff == `EE_LAST_BIT) begin
                        nxt_bit = `EE_ACK_BIT;
                        nxt_oe  = 1'b1;
                        case (state_ff)
                            ST_DEVADR: begin
                                if (!addr_hit) begin
                                    nxt_state = ST_IDLE;
                                    nxt_oe    = 1'b0;
                                end
                            end
                            ST_ADRH: begin
                                nxt_ptr[`EE_ADDR_BITS-1:8] =
                                    shift_ff[`EE_ADRH_MSB:`EE_ADRH_LSB];
                            end
                            ST_ADRL: begin
                                nxt_ptr[7:0] = shift_ff;
                                nxt_mask     = '0;
                                nxt_page     = nxt_ptr[`EE_ADDR_BITS-1:`EE_BYTE_BITS];
                            end
                            ST_WDATA: begin
                                buf_we   = 1'b1;
                                nxt_mask[ptr_ff[`EE_BYTE_BITS-1:0]] = 1'b1;
                                nxt_ptr[`EE_BYTE_BITS-1:0] =
                                    ptr_ff[`EE_BYTE_BITS-1:0] + 6'h01;
                            end
                            default: begin
                                nxt_oe = 1'b0; // master owns the ack slot
                            end
                        endcase
                    end else begin
                        nxt_bit = 4'h0;
                        nxt_oe  = 1'b0;
                        case (state_ff)
                            ST_DEVADR: begin
                                if (shift_ff[`EE_SA_RW_BIT]) begin
                                    nxt_state = ST_RDATA;
                                end else begin
                                    nxt_state = ST_ADRH;
                                end
                            end
                            ST_ADRH:  nxt_state = ST_ADRL;
                            ST_ADRL:  nxt_state = ST_WDATA;
                            ST_RDATA: begin
                                if (!mack_ff) begin
                                    nxt_state = ST_IDLE;
                                end
                            end
                            default:  nxt_state = state_ff;
                        endcase
                        // next read byte leaves on this falling edge
                        if (nxt_state == ST_RDATA) begin
                            nxt_shift = mem_arr[ptr_ff];
                            nxt_oe    = ~mem_arr[ptr_ff][7];
                            nxt_ptr   = ptr_ff + 13'h0001;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_POR;
            bit_ff   <= 4'h0;
            shift_ff <= 8'h00;
            oe_ff    <= 1'b0;
            mack_ff  <= 1'b0;
            ptr_ff   <= 13'h0000;
            mask_ff  <= '0;
            page_ff  <= 7'h00;
            busy_ff  <= 1'b0;
            tmr_ff   <= 32'h0000_0000;
            cidx_ff  <= 7'h00;
            bus_q_ff <= 2'h3;
        end else begin
            state_ff <= nxt_state;
            bit_ff   <= nxt_bit;
            shift_ff <= nxt_shift;
            oe_ff    <= nxt_oe;
            mack_ff  <= nxt_mack;
            ptr_ff   <= nxt_ptr;
            mask_ff  <= nxt_mask;
            page_ff  <= nxt_page;
            busy_ff  <= nxt_busy;
            tmr_ff   <= nxt_tmr;
            cidx_ff  <= nxt_cidx;
            bus_q_ff <= bus;
        end
    end

    // arrays carry no reset; contents are undefined until written
    always_ff @(posedge clk_i) begin
        if (buf_we) begin
            page_buf[ptr_ff[`EE_BYTE_BITS-1:0]] <= shift_ff;
        end
        if (mem_we) begin
            mem_arr[{page_ff, cidx_lo}] <= page_buf[cidx_lo];
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign sda_o    = 1'b0;
    assign sda_oe_o = oe_ff;
    assign busy_o   = busy_ff;
    assign ready_o  = (state_ff != ST_POR);

endmodule

// ---- testbench/ee_slave_sva.sv ----
`timescale 1ns/1ps
// ********************
// slave port checker
// ********************
module ee_slave_sva #(
    parameter int WR_CYCLES = 100, // write cycle length
    parameter int PU_CYCLES = 20,  // ready delay
    parameter int FILT_CYC  = 10   // filter length
) (
    input wire logic clk_i,               // clock
    input wire logic rst_n_i,             // reset, active low
    input wire logic scl_i,               // clock pin
    input wire logic sda_i,               // data pin
    input wire logic sda_o,               // drive value
    input wire logic sda_oe_o,            // pull enable
    input wire logic select_strap_bit0_i, // strap 0
    input wire logic select_strap_bit1_i, // strap 1
    input wire logic select_strap_bit2_i, // strap 2
    input wire logic wp_i,                // write protect
    input wire logic ready_o,             // ready
    input wire logic busy_o               // write cycle
);
    logic [7:0] fall_ff;
    logic [7:0] nxt_fall;
    logic       scl_ff;
    int         pu_ff;
    int         nxt_pu;
    int         busy_ff;
    int         nxt_busy;
    // cycles since pin clock fell, since reset, and spent busy
    always_comb begin
        nxt_fall = (scl_ff && !scl_i) ? 8'h01 : fall_ff + 8'(fall_ff != 8'hff);
        nxt_pu   = pu_ff + 1;
        nxt_busy = busy_o ? busy_ff + 1 : 0;
    end
    // saturated fall count so no change is allowed before the first fall
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_ff  <= 1'h1;
            fall_ff <= 8'hff;
            pu_ff   <= 0;
            busy_ff <= 0;
        end else begin
            scl_ff  <= scl_i;
            fall_ff <= nxt_fall;
            pu_ff   <= nxt_pu;
            busy_ff <= nxt_busy;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_sda_low_only: assert property (sda_o == 1'h0)
        else $error("data line driven high");
    a_oe_after_fall: assert property ($changed(sda_oe_o) |->
        fall_ff inside {[1:FILT_CYC + 8]})
        else $error("data out moved away from clock fall");
    a_ready_delay: assert property ($rose(ready_o) |->
        pu_ff inside {[PU_CYCLES - 2:PU_CYCLES + 2]})
        else $error("ready delay wrong");
    a_ready_holds: assert property (ready_o |=> ready_o)
        else $error("ready dropped without reset");
    a_quiet_early: assert property (!ready_o |-> !sda_oe_o && !busy_o)
        else $error("activity before ready");
    a_busy_len: assert property ($fell(busy_o) |->
        busy_ff inside {[WR_CYCLES - 1:WR_CYCLES + 1]})
        else $error("write cycle length wrong");
    a_busy_no_ack: assert property (busy_o |-> !sda_oe_o)
        else $error("acknowledge during write cycle");
    a_busy_at_stop: assert property ($rose(busy_o) |-> scl_i && sda_i)
        else $error("write cycle started outside stop");
    a_wp_no_cycle: assert property ($rose(busy_o) |-> !wp_i)
        else $error("write cycle while protected");
    c_ready: cover property ($rose(ready_o));
    c_ack: cover property ($rose(sda_oe_o));
    c_busy_end: cover property ($fell(busy_o));
endmodule

// ---- testbench/ee_tb_master.sv ----
`timescale 1ns/1ps
// ********************
// bus master model
// ********************
module ee_tb_master (
    input  wire logic clk_i,     // bench clock
    input  wire logic sda_i,     // resolved data line
    output logic      scl_o,     // serial clock
    output logic      sda_low_o  // high pulls data low
);
    logic tg = 1'h0;
    // idle bus: clock high, data released to pull-up
    initial begin
        scl_o = 1'h1;
        sda_low_o = 1'h0;
    end
    // whole cycles; every change lands on a falling edge
    task cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // low 8 or 9, high 4: 125 ns mean, long low lets slave answer settle
    task bit_x(input logic b, output logic r);
        cyc(2);
        sda_low_o = ~b;
        cyc(6 + int'(tg));
        tg = ~tg;
        scl_o = 1'h1;
        cyc(4);
        r = sda_i;
        scl_o = 1'h0;
    endtask
    task start;
        cyc(2);
        sda_low_o = 1'h0;
        cyc(8);
        scl_o = 1'h1;
        cyc(6);
        sda_low_o = 1'h1;
        cyc(6);
        scl_o = 1'h0;
    endtask
    task stop;
        cyc(2);
        sda_low_o = 1'h1;
        cyc(8);
        scl_o = 1'h1;
        cyc(6);
        sda_low_o = 1'h0;
        cyc(10);
    endtask
    // data dip while clock high, then clock falls with no condition
    task glitch(input int n);
        sda_low_o = 1'h1;
        cyc(n);
        sda_low_o = 1'h0;
        cyc(6);
        scl_o = 1'h0;
    endtask
    task wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], r);
        end
        bit_x(1'h1, r);
        ack = ~r;
    endtask
    task rbyte(input logic mack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'h1, b[i]);
        end
        bit_x(~mack, r);
    endtask
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`include "ee_map.svh"
module testbench;
    import ee_pkg::*;
    localparam int WR = 400;
    localparam int PU = 400;
    localparam int FC = 2;
    logic      clk = 1'h0;
    logic      rst_n = 1'h0;
    ee_strap_s strap = 4'h0;
    logic      scl;
    logic      m_low;
    logic      sda_d;
    logic      sda_oe;
    logic      rdy;
    logic      busy;
    logic      sda_w;
    int        bad_count = 0;
    int        num_checks = 0;
    always #5 clk = ~clk;
    // open drain wire with pull-up
    assign sda_w = (sda_oe ? sda_d : 1'h1) & ~m_low;
    ee_slave #(.WR_CYCLES(WR), .PU_CYCLES(PU), .FILT_CYC(FC)) ee_slave_inst (
        .clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_d),
        .sda_oe_o(sda_oe), .select_strap_bit0_i(strap.sel[0]),
        .select_strap_bit1_i(strap.sel[1]), .select_strap_bit2_i(strap.sel[2]),
        .wp_i(strap.wp), .ready_o(rdy), .busy_o(busy));
    ee_tb_master ee_tb_master_inst (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(m_low));
    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task adr(input logic [2:0] s, input logic rw, output logic a);
        ee_tb_master_inst.start();
        ee_tb_master_inst.wbyte({`EE_DEV_TYPE, s, rw}, a);
    endtask
    task wr_hdr(input logic [7:0] hi, input logic [7:0] lo);
        logic a;
        adr(strap.sel, 1'h0, a);
        chk(8'(a), 8'h01, "slave ack");
        ee_tb_master_inst.wbyte(hi, a);
        chk(8'(a), 8'h01, "addr hi ack");
        ee_tb_master_inst.wbyte(lo, a);
        chk(8'(a), 8'h01, "addr lo ack");
    endtask
    // dummy write sets the pointer, repeated start reads two bytes
    task rd2(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] e0,
             input logic [7:0] e1);
        logic [7:0] d;
        logic       a;
        wr_hdr(hi, lo);
        adr(strap.sel, 1'h1, a);
        chk(8'(a), 8'h01, "read ack");
        ee_tb_master_inst.rbyte(1'h1, d);
        chk(d, e0, "read 0");
        ee_tb_master_inst.rbyte(1'h0, d);
        chk(d, e1, "read 1");
        ee_tb_master_inst.stop();
    endtask
    task wait_idle;
        int n;
        n = 0;
        while (busy !== 1'h0 && n < WR + 50) begin
            @(negedge clk);
            n++;
        end
        chk(8'(busy), 8'h00, "cycle end");
    endtask
    task wait_rdy;
        int n;
        n = 0;
        while (rdy !== 1'h1 && n < PU) begin
            @(negedge clk);
            n++;
        end
        chk(8'(rdy), 8'h01, "ready");
    endtask
    // traffic before ready is ignored
    task t_reset;
        logic a;
        repeat (3) @(negedge clk);
        chk({5'h00, rdy, busy, sda_oe}, 8'h00, "in reset");
        rst_n = 1'h1;
        adr(3'h0, 1'h0, a);
        ee_tb_master_inst.stop();
        chk(8'(a), 8'h00, "early ack");
        wait_rdy();
        $display("test reset done");
    endtask
    // reset in the middle of a write cycle drops busy and restarts the ready delay
    task t_rerst;
        logic a;
        wr_hdr(8'h02, 8'h00);
        ee_tb_master_inst.wbyte(8'hc3, a);
        ee_tb_master_inst.stop();
        chk(8'(busy), 8'h01, "busy before reset");
        rst_n = 1'h0;
        repeat (3) @(negedge clk);
        chk({5'h00, rdy, busy, sda_oe}, 8'h00, "mid reset");
        rst_n = 1'h1;
        repeat (2) @(negedge clk);
        chk(8'(rdy), 8'h00, "ready after release");
        wait_rdy();
        adr(strap.sel, 1'h0, a);
        ee_tb_master_inst.stop();
        chk(8'(a), 8'h01, "ack after reset");
        $display("test mid reset done");
    endtask
    task t_select;
        logic a;
        strap.sel = 3'h5;
        for (int s = 0; s < 8; s++) begin
            adr(s[2:0], 1'h0, a);
            ee_tb_master_inst.stop();
            chk(8'(a), 8'(s == 5), "select");
        end
        ee_tb_master_inst.start();
        ee_tb_master_inst.wbyte(8'hba, a);
        ee_tb_master_inst.stop();
        chk(8'(a), 8'h00, "prefix");
        $display("test select done");
    endtask
    // 66 bytes from the page's last two: wrap overwrites those last two again
    task t_page;
        logic a;
        wr_hdr(8'he1, 8'h3e);
        for (int i = 0; i < 66; i++) begin
            ee_tb_master_inst.wbyte(i[7:0], a);
            chk(8'(a), 8'h01, "data ack");
        end
        ee_tb_master_inst.stop();
        chk(8'(busy), 8'h01, "busy");
        adr(strap.sel, 1'h0, a);
        ee_tb_master_inst.stop();
        chk(8'(a), 8'h00, "poll");
        wait_idle();
        rd2(8'h01, 8'h3e, 8'h40, 8'h41);
        rd2(8'h21, 8'h00, 8'h02, 8'h03);
        $display("test page done");
    endtask
    task t_wp;
        logic a;
        strap.wp = 1'h1;
        wr_hdr(8'h01, 8'h00);
        ee_tb_master_inst.wbyte(8'h5a, a);
        chk(8'(a), 8'h01, "protected ack");
        ee_tb_master_inst.stop();
        chk(8'(busy), 8'h00, "no cycle");
        strap.wp = 1'h0;
        rd2(8'h01, 8'h00, 8'h02, 8'h03);
        $display("test protect done");
    endtask
    // one-cycle dip is under the filter, so no start is seen
    task t_glitch;
        logic a;
        ee_tb_master_inst.glitch(FC - 1);
        ee_tb_master_inst.wbyte({`EE_DEV_TYPE, strap.sel, 1'h0}, a);
        ee_tb_master_inst.stop();
        chk(8'(a), 8'h00, "glitch");
        $display("test glitch done");
    endtask
    initial begin
        t_reset();
        t_select();
        t_page();
        t_wp();
        t_glitch();
        t_rerst();
        finish_test();
    end
    // watchdog: about three and a half times the expected run
    initial begin
        repeat (50000) @(posedge clk);
        bad_count++;
        $display("CHECK FAILED t=%0t watchdog", $time);
        finish_test();
    end
endmodule
bind ee_slave ee_slave_sva #(.WR_CYCLES(WR_CYCLES), .PU_CYCLES(PU_CYCLES), .FILT_CYC(FILT_CYC))
    ee_slave_sva_inst (.clk_i, .rst_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
    .select_strap_bit0_i, .select_strap_bit1_i, .select_strap_bit2_i, .wp_i, .ready_o, .busy_o);
